/* hdl/ems_access_sequencer.sv */
/*
  Cycle-level access sequencer of the external memory port. Splits one
  24-bit internal word into byte or nibble phases toward DRAM or SRAM.
  Assumes the core holds its request fields stable while start is high and
  that memDataIn is synchronous to clk. Refresh and address arithmetic
  live elsewhere.
*/
// How it works
// - dram timing select 0 picks fast timing, 1 picks slow timing.
// - 8-bit words and absolute accesses use internal bits 23 to 16.
// - 16-bit words occupy internal bits 23 to 8.
// - 20-bit words on the nibble bus occupy bits 23 to 4.
// - 20, 24 and 12-bit words are left-justified in the internal word.
// - one byte or one nibble per phase, most significant first.
// - fast dram: three setup, three per phase, two finishing cycles.
// - slow dram: four setup, four per phase, four finishing cycles.
// - sram access: two setup, one to sixteen waits, one final cycle.
// - sram moves a word in one to six successive accesses.
`timescale 1ns/1ps
module ems_access_sequencer (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // core request
  input  wire logic                         start,
  output logic                              startReady,
  input  wire logic                         readNotWrite,
  input  wire logic                         dramMode,
  input  wire logic                         dramTimingSelect,
  input  wire logic [3:0]                   sramWaitSelect,
  input  wire logic                         wideBus,
  input  wire ems_pkg::ems_fmt_e            wordFmt,
  input  wire logic [ems_pkg::ADDR_W-1:0]   rowAddr,
  input  wire logic [ems_pkg::ADDR_W-1:0]   colAddr,
  input  wire logic [ems_pkg::WORD_W-1:0]   writeData,
  output logic                              accessDone,
  // read words toward the core
  output logic                              readValid,
  input  wire logic                         readReady,
  output logic [ems_pkg::WORD_W-1:0]        readData,
  // memory pins
  output logic [ems_pkg::ADDR_W-1:0]        memAddr,
  output logic                              rowStrobe_n,
  output logic                              columnStrobe_n,
  output logic                              readStrobe_n,
  output logic                              writeStrobe_n,
  output logic [ems_pkg::BYTE_W-1:0]        memDataOut,
  output logic                              memDataOe,
  input  wire logic [ems_pkg::BYTE_W-1:0]   memDataIn
);

  // ---------------------------------------------------------------
  // latched request and sequencer state
  // ---------------------------------------------------------------
  ems_pkg::ems_state_e              state_r;
  ems_pkg::ems_state_e              state_nxt;
  logic [ems_pkg::CNT_W-1:0]        cnt_r;
  logic [ems_pkg::PH_W-1:0]         phase_r;
  logic                             rd_r;
  logic                             dram_r;
  logic                             slow_r;
  logic                             wide_r;
  logic [3:0]                       wait_r;
  ems_pkg::ems_fmt_e                fmt_r;
  logic [ems_pkg::ADDR_W-1:0]       row_r;
  logic [ems_pkg::ADDR_W-1:0]       col_r;
  logic [ems_pkg::WORD_W-1:0]       shift_r;
  logic [ems_pkg::WORD_W-1:0]       acc_r;

  // ---------------------------------------------------------------
  // buffer of finished read words
  // ---------------------------------------------------------------
  logic [ems_pkg::WORD_W-1:0]       buf_r [2];
  logic [1:0]                       bufCnt_r;
  logic                             head_r;
  logic                             push;
  logic                             pop;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [ems_pkg::CNT_W-1:0] setupLen =
    !dram_r ? ems_pkg::SRAM_SETUP :
    slow_r  ? ems_pkg::SLOW_SETUP : ems_pkg::FAST_SETUP;
  wire logic [ems_pkg::CNT_W-1:0] phaseLen =
    !dram_r ? ems_pkg::SRAM_WAIT0 + {1'b0, wait_r} :
    slow_r  ? ems_pkg::SLOW_PHASE : ems_pkg::FAST_PHASE;
  wire logic [ems_pkg::CNT_W-1:0] finishLen =
    !dram_r ? ems_pkg::SRAM_FINAL :
    slow_r  ? ems_pkg::SLOW_FINISH : ems_pkg::FAST_FINISH;
  wire logic [ems_pkg::CNT_W-1:0] stateLen =
    (state_r == ems_pkg::ST_SETUP) ? setupLen :
    (state_r == ems_pkg::ST_PHASE) ? phaseLen : finishLen;
  wire logic lastCyc = (cnt_r == stateLen - 5'h01);
  wire logic [ems_pkg::PH_W-1:0] nPhases =
    ems_pkg::phaseCount(fmt_r, wide_r);
  wire logic lastPhase = (phase_r == nPhases - 3'h1);
  wire logic inPhase = (state_r == ems_pkg::ST_PHASE);
  wire logic busy = (state_r != ems_pkg::ST_IDLE);
  wire logic finishing = (state_r == ems_pkg::ST_FINISH) && lastCyc;
  wire logic [5:0] xferBits =
    wide_r ? {nPhases, 3'h0} : {1'b0, nPhases, 2'h0};
  wire logic [5:0] alignSh = 6'h18 - xferBits;
  wire logic [ems_pkg::WORD_W-1:0] keepMask =
    ~(24'hffffff >> ems_pkg::fmtBits(fmt_r));
  // reads shift in at the bottom and are left-justified at the end
  wire logic [ems_pkg::WORD_W-1:0] readWord =
    (acc_r << alignSh) & keepMask;
  wire logic [ems_pkg::WORD_W-1:0] accIn =
    wide_r ? {acc_r[15:0], memDataIn}
           : {acc_r[19:0], memDataIn[3:0]};
  wire logic [ems_pkg::WORD_W-1:0] shiftIn =
    wide_r ? {shift_r[15:0], 8'h00} : {shift_r[19:0], 4'h0};
  // a read only starts when the buffer can take its word
  assign startReady = !busy && (!readNotWrite || bufCnt_r != 2'h2);
  wire logic take     = start && startReady;
  wire logic inSetup  = (state_r == ems_pkg::ST_SETUP);
  wire logic shiftNow = inPhase && lastCyc;
  // a whole word ends after one dram access or the last sram access
  wire logic wordDone = finishing && (dram_r || lastPhase);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ems_pkg::ST_IDLE:
        if (take) begin
          state_nxt = ems_pkg::ST_SETUP;
        end
      ems_pkg::ST_SETUP:
        if (lastCyc) begin
          state_nxt = ems_pkg::ST_PHASE;
        end
      ems_pkg::ST_PHASE:
        if (lastCyc && (!dram_r || lastPhase)) begin
          state_nxt = ems_pkg::ST_FINISH;
        end
      ems_pkg::ST_FINISH:
        if (lastCyc) begin
          // sram runs one full access per phase
          state_nxt = (dram_r || lastPhase) ? ems_pkg::ST_IDLE
                                            : ems_pkg::ST_SETUP;
        end
      default: state_nxt = ems_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // counter and phase next values
  // ---------------------------------------------------------------
  wire logic restartCnt = (state_nxt != state_r) || lastCyc;
  // dram steps per data phase, sram per finished access
  wire logic stepPhase  = lastCyc && (dram_r ? inPhase : finishing);
  wire logic [ems_pkg::CNT_W-1:0] cnt_nxt =
    restartCnt ? '0 : cnt_r + 5'h01;
  wire logic [ems_pkg::PH_W-1:0] phase_nxt =
    !busy     ? '0 :
    stepPhase ? phase_r + 3'h1 : phase_r;

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ems_pkg::ST_IDLE;
      cnt_r   <= '0;
      phase_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r    <= 1'b0;
      dram_r  <= 1'b0;
      slow_r  <= 1'b0;
      wide_r  <= 1'b0;
      wait_r  <= '0;
      fmt_r   <= ems_pkg::FMT_W8;
      row_r   <= '0;
      col_r   <= '0;
    end else if (take) begin
      rd_r    <= readNotWrite;
      dram_r  <= dramMode;
      slow_r  <= dramTimingSelect;
      wide_r  <= wideBus;
      wait_r  <= sramWaitSelect;
      fmt_r   <= wordFmt;
      row_r   <= rowAddr;
      col_r   <= colAddr;
    end
  end

  // data path: loaded at take, shifted once at the end of each phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      acc_r   <= '0;
    end else if (take) begin
      shift_r <= writeData;
      acc_r   <= '0;
    end else if (shiftNow) begin
      shift_r <= shiftIn;
      if (rd_r) begin
        acc_r <= accIn;
      end
    end
  end

  // ---------------------------------------------------------------
  // read buffer: two entries so a stalled reader loses no word
  // ---------------------------------------------------------------
  assign push = wordDone && rd_r;
  assign pop  = readValid && readReady;
  // a new word goes behind the one already waiting at the head
  wire logic wrSlot = head_r ^ bufCnt_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufCnt_r <= '0;
      head_r   <= 1'b0;
    end else begin
      if (pop) begin
        head_r <= ~head_r;
      end
      bufCnt_r <= bufCnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  for (genvar e = 0; e < 2; e++) begin : g_entry
    wire logic load = push && (wrSlot == 1'(e));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        buf_r[e] <= '0;
      end else if (load) begin
        buf_r[e] <= readWord;
      end
    end
  end

  assign readValid = (bufCnt_r != 2'h0);
  assign readData  = buf_r[head_r];

  // ---------------------------------------------------------------
  // pin decode
  // ---------------------------------------------------------------
  wire logic rowActive = dram_r && busy && !inSetup;
  // column strobe low after the first cycle so the address settles
  wire logic colActive = dram_r && inPhase && (cnt_r != '0);
  wire logic rdActive  = inPhase && rd_r;
  wire logic wrActive  = inPhase && !rd_r;
  wire logic [ems_pkg::ADDR_W-1:0] phaseOff =
    {{(ems_pkg::ADDR_W-ems_pkg::PH_W){1'b0}}, phase_r};
  wire logic [ems_pkg::BYTE_W-1:0] byteOut = shift_r[23:16];
  wire logic [ems_pkg::BYTE_W-1:0] nibOut  = {4'h0, shift_r[23:20]};

  // ---------------------------------------------------------------
  // memory pins
  // ---------------------------------------------------------------
  assign accessDone = wordDone;
  // row address while a dram access sets up, otherwise one column per phase
  assign memAddr = (dram_r && inSetup) ? row_r
                 : col_r + phaseOff;
  assign rowStrobe_n    = !rowActive;
  assign columnStrobe_n = !colActive;
  assign readStrobe_n   = !rdActive;
  assign writeStrobe_n  = !wrActive;
  assign memDataOe      = wrActive;
  assign memDataOut     = wide_r ? byteOut : nibOut;

endmodule

/* hdl/ems_pkg.sv */
/*
  Shared constants and types for the external memory port access sequencer:
  word formats, sequencer states and the cycle counts of each access piece.
  Assumes a single processor clock; all counts are in those clock cycles.
*/
package ems_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned CNT_W  = 5;
  localparam int unsigned PH_W   = 3;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W  = 4;

  // ---------------------------------------------------------------
  // cycle counts per piece of an access
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] FAST_SETUP  = 5'h03;
  localparam logic [CNT_W-1:0] FAST_PHASE  = 5'h03;
  localparam logic [CNT_W-1:0] FAST_FINISH = 5'h02;
  localparam logic [CNT_W-1:0] SLOW_SETUP  = 5'h04;
  localparam logic [CNT_W-1:0] SLOW_PHASE  = 5'h04;
  localparam logic [CNT_W-1:0] SLOW_FINISH = 5'h04;
  localparam logic [CNT_W-1:0] SRAM_SETUP  = 5'h02;
  localparam logic [CNT_W-1:0] SRAM_FINAL  = 5'h01;
  localparam logic [CNT_W-1:0] SRAM_WAIT0  = 5'h01;

  // ---------------------------------------------------------------
  // word formats and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_W8,
    FMT_W12,
    FMT_W16,
    FMT_W20,
    FMT_W24
  } ems_fmt_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PHASE,
    ST_FINISH
  } ems_state_e;

  // significant bits of each word format
  function automatic logic [5:0] fmtBits(input ems_fmt_e f);
    unique case (f)
      FMT_W8:  fmtBits = 6'h08;
      FMT_W12: fmtBits = 6'h0c;
      FMT_W16: fmtBits = 6'h10;
      FMT_W20: fmtBits = 6'h14;
      FMT_W24: fmtBits = 6'h18;
    endcase
  endfunction

  // data phases (or sram accesses) needed for one internal word
  function automatic logic [PH_W-1:0] phaseCount(input ems_fmt_e f,
                                                  input logic wide);
    unique case (f)
      FMT_W8:  phaseCount = wide ? 3'h1 : 3'h2;
      FMT_W12: phaseCount = wide ? 3'h2 : 3'h3;
      FMT_W16: phaseCount = wide ? 3'h2 : 3'h4;
      FMT_W20: phaseCount = wide ? 3'h3 : 3'h5;
      FMT_W24: phaseCount = wide ? 3'h3 : 3'h6;
    endcase
  endfunction

endpackage

/* verif/ems_mem_model.sv */
/* memory device model answering reads on the data pins.
   assumes address and read strobe come from the sequencer on clk. */
`timescale 1ns/1ps
module ems_mem_model (
  // memory pins
  input  wire logic       clk,
  input  wire logic [8:0] memAddr,
  input  wire logic       readStrobe_n,
  output logic      [7:0] memDataIn
);
  // released bus toggles every cycle so a stale byte never passes
  logic [7:0] junk_r = 8'h3c;
  always @(posedge clk) junk_r <= ~junk_r;
  assign memDataIn = readStrobe_n ? junk_r :
                     memAddr[7:0] ^ 8'h5a ^ {memAddr[8], 7'h00};
endmodule

/* verif/ems_seq_checker.sv */
/* assertions on the access sequencer ports, bound into the design.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
module ems_seq_checker (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // core side
  input wire logic              start,
  input wire logic              startReady,
  input wire logic              dramMode,
  input wire logic              dramTimingSelect,
  input wire logic              wideBus,
  input wire logic [3:0]        sramWaitSelect,
  input wire ems_pkg::ems_fmt_e wordFmt,
  input wire logic [8:0]        rowAddr,
  input wire logic              accessDone,
  // memory pins
  input wire logic [8:0]        memAddr,
  input wire logic              rowStrobe_n,
  input wire logic              columnStrobe_n,
  input wire logic              readStrobe_n,
  input wire logic              writeStrobe_n,
  input wire logic              memDataOe
);
  logic       busy_r;
  logic [7:0] cnt_r, exp_r, bits, n, expNxt;
  wire        take = start && startReady;
  // whole word length, counted from the take edge
  assign bits   = 8'h08 + {3'h0, wordFmt, 2'h0};
  assign n      = wideBus ? (bits + 8'h07) >> 3 : bits >> 2;
  assign expNxt = !dramMode ? n * ({4'h0, sramWaitSelect} + 8'h04) :
                  dramTimingSelect ? 8'h08 + 8'h04 * n : 8'h05 + 8'h03 * n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
      exp_r  <= 8'h00;
    end else if (busy_r) begin
      busy_r <= !accessDone;
      cnt_r  <= cnt_r + 8'h01;
    end else if (take) begin
      busy_r <= 1'b1;
      cnt_r  <= 8'h01;
      exp_r  <= expNxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take_dram;
    take && dramMode;
  endsequence
  sequence s_take_sram;
    take && !dramMode;
  endsequence
  a_done_exact: assert property (
    accessDone == (busy_r && cnt_r == exp_r)) else $error("done cycle off");
  a_fast_setup: assert property (
    s_take_dram ##0 !dramTimingSelect |=> rowStrobe_n[*3] ##1 !rowStrobe_n)
    else $error("fast row setup off");
  a_slow_setup: assert property (
    s_take_dram ##0 dramTimingSelect |=> rowStrobe_n[*4] ##1 !rowStrobe_n)
    else $error("slow row setup off");
  a_col_fast: assert property (
    s_take_dram ##0 !dramTimingSelect |=> ##3 columnStrobe_n
    ##1 !columnStrobe_n) else $error("fast column strobe off");
  a_col_slow: assert property (
    s_take_dram ##0 dramTimingSelect |=> ##4 columnStrobe_n
    ##1 !columnStrobe_n) else $error("slow column strobe off");
  a_row_addr: assert property (
    s_take_dram |=> memAddr == $past(rowAddr)) else $error("row address off");
  a_sram_setup: assert property (
    s_take_sram |=> (readStrobe_n && writeStrobe_n)[*2]
    ##1 !(readStrobe_n && writeStrobe_n)) else $error("sram setup off");
  a_strobe_excl: assert property (
    readStrobe_n || writeStrobe_n) else $error("both strobes low");
  a_oe_write: assert property (
    memDataOe == !writeStrobe_n) else $error("data enable off");
  a_col_in_row: assert property (
    !columnStrobe_n |-> !rowStrobe_n) else $error("column without row");
  a_idle_quiet: assert property (
    !busy_r |-> rowStrobe_n && readStrobe_n && writeStrobe_n && !memDataOe)
    else $error("strobe while idle");
endmodule
bind ems_access_sequencer ems_seq_checker i_ems_seq_checker (.*);

/* verif/tb.sv */
/* self-checking bench: sweeps modes and formats, then fills the buffer.
   assumes request fields matter only at the take edge. */
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_compared++; if ((ex) !== (sn)) begin \
  failures++; $display("MISMATCH %s exp %h seen %h", nm, ex, sn); end end
module tb;
  logic        clk, rst_n, start, readNotWrite, dramMode, dramTimingSelect;
  logic        wideBus, readReady, startReady, accessDone, readValid;
  logic        rowStrobe_n, columnStrobe_n, readStrobe_n, writeStrobe_n;
  logic        memDataOe;
  logic [3:0]  sramWaitSelect;
  logic [8:0]  rowAddr, colAddr, memAddr;
  logic [23:0] writeData, readData;
  logic [7:0]  memDataOut, memDataIn;
  logic [7:0]  wr [int];
  logic [23:0] expQ [$];
  ems_pkg::ems_fmt_e wordFmt;
  int          failures = 0, n_compared = 0, seed = 32'hb4d97889;
  ems_access_sequencer i_ems_access_sequencer (.*);
  ems_mem_model        i_ems_mem_model (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // 82 accesses of at most 120 cycles each, with margin
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
  always @(negedge clk) if (memDataOe === 1'b1) wr[memAddr] = memDataOut;
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(input logic rd);
    logic [23:0] w, m;
    logic [8:0]  a;
    logic [7:0]  b;
    int          n, bits, tot, cnt;
    bits = 8 + 4 * int'(wordFmt);
    n = wideBus ? (bits + 7) / 8 : bits / 4;
    tot = !dramMode ? n * (sramWaitSelect + 4) :
          dramTimingSelect ? 8 + 4 * n : 5 + 3 * n;
    m = ~(24'hffffff >> bits);
    wr.delete();
    @(posedge clk);
    #1 readNotWrite = rd;
    writeData = writeData & m;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
      if (cnt == 1 && dramMode) `CHK("row", rowAddr, memAddr)
    end while (accessDone !== 1'b1 && cnt < 200);
    `CHK("cycles", tot, cnt)
    w = '0;
    for (int p = 0; p < n; p++) begin
      a = colAddr + 9'(p);
      if (wideBus) b = writeData[23-8*p -: 8];
      else b = {4'h0, writeData[23-4*p -: 4]};
      if (!rd) `CHK("wrByte", b, wr[a])
      b = a[7:0] ^ 8'h5a ^ {a[8], 7'h00};
      if (wideBus) w[23-8*p -: 8] = b;
      else w[23-4*p -: 4] = b[3:0];
    end
    if (rd) expQ.push_back(w & m);
  endtask
  task automatic pop();
    logic [23:0] e;
    int          k;
    k = 0;
    while (readValid !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    e = expQ.pop_front();
    `CHK("readData", e, readData)
    @(posedge clk);
    #1 readReady = 1'b1;
    @(posedge clk);
    #1 readReady = 1'b0;
  endtask
  initial begin
    {rst_n, start, readNotWrite, dramMode, dramTimingSelect} = '0;
    {wideBus, readReady, sramWaitSelect, rowAddr, colAddr} = '0;
    writeData = '0;
    wordFmt = ems_pkg::FMT_W8;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      #1 {dramMode, dramTimingSelect, wideBus} = i[2:0];
      wordFmt = ems_pkg::ems_fmt_e'(i[5:3] % 5);
      {sramWaitSelect, rowAddr, colAddr} = 22'($random(seed));
      writeData = 24'($random(seed));
      if (expQ.size() == 2) pop();
      access(1'($random(seed)));
      if (expQ.size() > 0 && $random(seed) % 2 != 0) pop();
    end
    while (expQ.size() > 0) pop();
    $display("test sweep done");
    // two unread words fill the buffer, so a third read must wait
    access(1'b1);
    access(1'b1);
    @(posedge clk);
    #1 start = 1'b1;
    repeat (10) begin
      @(negedge clk);
      `CHK("refused", 2'b00, {startReady, accessDone})
    end
    @(posedge clk);
    #1 start = 1'b0;
    pop();
    pop();
    $display("test buffer full done");
    print_verdict();
  end
endmodule
